// >>> rtl/spr_port.sv
// How it works
// - Serial clock idles low between transfers
// - Both sides drive data on first edge
// - Reply shifts out during the word after the command
// - First sixteen bits after select fall: command
// - Following words stored only for write commands
// - Top command bit: one read, zero write
// - Bits 14..11 page; only 0..2 valid
// - Bits 10..5 register address in page
// - Bits 4..0 ignored by device
// - Command 0x8000 reads page zero from register zero
// - Pointer advances by one per word
// - Reads beyond page end return 0xFFFF
// - Write 0x10E0 then fills consecutive coefficients
// - Ready low on new results, high once every pending result is read
// - Results are stored as straight binary
// - Every register and data word is sixteen bits
// - Page zero results, one control, two audio
`default_nettype none
module spr_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic result_valid,
    input wire spr_pkg::spr_result_t result,
    output logic result_ready_n,
    output logic reg_wr_valid,
    output spr_pkg::spr_reg_wr_t reg_wr
);
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CMD,
        PH_READ,
        PH_WRITE
    } spr_phase_t;

    typedef struct packed {
        logic [1:0] sclk_s;
        logic sclk_prev;
        logic [1:0] ss_s;
        logic ss_prev;
        logic [1:0] mosi_s;
        spr_phase_t phase;
        logic [3:0] bit_cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [3:0] page;
        logic [5:0] ptr;
        logic past;
        logic fetch;
        logic miso;
        logic miso_oe;
        logic [63:0] pending;
        logic rdy_n;
        logic wr_valid;
        spr_pkg::spr_reg_wr_t wr;
    } spr_port_st_t;

    spr_port_st_t st_q;
    spr_port_st_t st_d;
    logic [15:0] data_rd;
    logic [15:0] ctrl_rd;
    logic [15:0] word_in;
    logic sclk_rise;
    logic sclk_fall;
    logic ss_fall;
    logic page_ok;

    // Data page: filled by the measurement side, read by the master
    spr_mem #(
        .W(spr_pkg::WORD_W),
        .DEPTH(spr_pkg::PAGE_WORDS),
        .AW(spr_pkg::CMD_ADDR_W)
    ) u_data_page (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(result_valid),
        .wr_addr(result.addr),
        .wr_data(result.data),
        .rd_addr(st_d.ptr),
        .rd_data(data_rd)
    );

    // Control and audio pages share one array, page picks the top bit
    spr_mem #(
        .W(spr_pkg::WORD_W),
        .DEPTH(spr_pkg::CTRL_WORDS),
        .AW(spr_pkg::CTRL_AW)
    ) u_ctrl_pages (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(st_q.wr_valid),
        .wr_addr({st_q.wr.page == spr_pkg::PAGE_AUDIO, st_q.wr.addr}),
        .wr_data(st_q.wr.data),
        .rd_addr({st_d.page == spr_pkg::PAGE_AUDIO, st_d.ptr}),
        .rd_data(ctrl_rd)
    );

    // Edges seen only past the second synchroniser stage
    assign sclk_rise = st_q.sclk_s[1] && !st_q.sclk_prev;
    assign sclk_fall = !st_q.sclk_s[1] && st_q.sclk_prev;
    assign ss_fall = !st_q.ss_s[1] && st_q.ss_prev;
    assign word_in = {st_q.rx[14:0], st_q.mosi_s[1]};
    assign page_ok = (st_q.page == spr_pkg::PAGE_CTRL) || (st_q.page == spr_pkg::PAGE_AUDIO);

    always_comb
    begin
        st_d = st_q;
        st_d.sclk_s = {st_q.sclk_s[0], sclk};
        st_d.sclk_prev = st_q.sclk_s[1];
        st_d.ss_s = {st_q.ss_s[0], ss_n};
        st_d.ss_prev = st_q.ss_s[1];
        st_d.mosi_s = {st_q.mosi_s[0], mosi};
        st_d.wr_valid = 1'b0;
        st_d.fetch = 1'b0;
        // Word fetched last cycle lands in the shifter
        if (st_q.fetch)
        begin
            if (st_q.past || st_q.page > spr_pkg::PAGE_AUDIO)
            begin
                st_d.tx = spr_pkg::FILL_WORD;
            end
            else if (st_q.page == spr_pkg::PAGE_DATA)
            begin
                st_d.tx = data_rd;
            end
            else
            begin
                st_d.tx = ctrl_rd;
            end
        end
        if (st_q.ss_s[1])
        begin
            // Select high: whole frame abandoned, output released
            st_d.phase = PH_IDLE;
            st_d.miso_oe = 1'b0;
            st_d.miso = 1'b0;
        end
        else if (ss_fall)
        begin
            st_d.phase = PH_CMD;
            st_d.bit_cnt = spr_pkg::BIT_RST;
            st_d.tx = spr_pkg::WORD_RST;
            st_d.miso_oe = 1'b1;
        end
        else if (sclk_rise && st_q.phase != PH_IDLE)
        begin
            // Lead edge drives the next reply bit
            st_d.miso = st_q.tx[15];
            st_d.tx = {st_q.tx[14:0], 1'b0};
        end
        else if (sclk_fall && st_q.phase != PH_IDLE)
        begin
            // Trail edge samples the master's bit
            st_d.rx = word_in;
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
            if (st_q.bit_cnt == spr_pkg::BIT_LAST)
            begin
                case (st_q.phase)
                    PH_CMD:
                    begin
                        // Low five bits carry nothing
                        st_d.page = word_in[14:11];
                        st_d.ptr = word_in[10:5];
                        st_d.past = 1'b0;
                        st_d.phase = word_in[spr_pkg::CMD_RW_BIT] ? PH_READ : PH_WRITE;
                        st_d.fetch = word_in[spr_pkg::CMD_RW_BIT];
                    end
                    PH_READ:
                    begin
                        if (st_q.page == spr_pkg::PAGE_DATA && !st_q.past)
                        begin
                            st_d.pending[st_q.ptr] = 1'b0;
                        end
                        st_d.fetch = 1'b1;
                    end
                    PH_WRITE:
                    begin
                        // Data page and reserved pages refuse writes silently
                        if (page_ok && !st_q.past)
                        begin
                            st_d.wr_valid = 1'b1;
                            st_d.wr = '{page: st_q.page, addr: st_q.ptr, data: word_in};
                        end
                    end
                    default:
                    begin
                        st_d.phase = PH_IDLE;
                    end
                endcase
                // Pointer stops at the last word, later words fall past it
                if (st_q.phase != PH_CMD)
                begin
                    if (st_q.ptr == spr_pkg::PTR_LAST)
                    begin
                        st_d.past = 1'b1;
                    end
                    else
                    begin
                        st_d.ptr = st_q.ptr + 6'h01;
                    end
                end
            end
        end
        // A new result wins over a read clearing the same word
        if (result_valid)
        begin
            st_d.pending[result.addr] = 1'b1;
        end
        st_d.rdy_n = ~|st_d.pending;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.ss_s <= spr_pkg::SYNC_HI_RST;
            st_q.ss_prev <= 1'b1;
            st_q.phase <= PH_IDLE;
            st_q.pending <= spr_pkg::PEND_RST;
            st_q.ptr <= spr_pkg::PTR_RST;
            st_q.rdy_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign miso = st_q.miso;
    assign miso_oe = st_q.miso_oe;
    assign result_ready_n = st_q.rdy_n;
    assign reg_wr_valid = st_q.wr_valid;
    assign reg_wr = st_q.wr;
endmodule : spr_port
`default_nettype wire

// >>> rtl/spr_pkg.sv
`default_nettype none
package spr_pkg;
    // Word and command layout
    localparam int WORD_W = 16;
    localparam int CMD_RW_BIT = 15;
    localparam int CMD_PAGE_LSB = 11;
    localparam int CMD_PAGE_W = 4;
    localparam int CMD_ADDR_LSB = 5;
    localparam int CMD_ADDR_W = 6;
    localparam int PAGE_WORDS = 64;
    localparam int CTRL_WORDS = 128;
    localparam int CTRL_AW = 7;

    // Page numbers
    localparam logic [3:0] PAGE_DATA = 4'h0;
    localparam logic [3:0] PAGE_CTRL = 4'h1;
    localparam logic [3:0] PAGE_AUDIO = 4'h2;

    // Fixed words and reset values
    localparam logic [15:0] FILL_WORD = 16'hFFFF;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [5:0] PTR_LAST = 6'h3F;
    localparam logic [5:0] PTR_RST = 6'h00;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [3:0] BIT_RST = 4'h0;
    localparam logic [63:0] PEND_RST = 64'h0000000000000000;
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic [1:0] SYNC_HI_RST = 2'h3;

    // Result written by the measurement side into the data page
    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] data;
    } spr_result_t;

    // Register word stored by the serial master
    typedef struct packed {
        logic [3:0] page;
        logic [5:0] addr;
        logic [15:0] data;
    } spr_reg_wr_t;
endpackage : spr_pkg
`default_nettype wire

// >>> rtl/spr_mem.sv
`default_nettype none
module spr_mem #(
    parameter int W = 16,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    typedef struct packed {
        logic [W-1:0] rd;
    } spr_mem_st_t;

    logic [W-1:0] mem [DEPTH];
    spr_mem_st_t st_q;
    spr_mem_st_t st_d;

    // Address width must reach every word
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
        $error("spr_mem: DEPTH does not fit AW");
    end

    // Array left unreset so it can map onto RAM
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data always come out of a register
    always_comb
    begin
        st_d = st_q;
        st_d.rd = mem[rd_addr];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd;
endmodule : spr_mem
`default_nettype wire

// >>> verification/spr_port_assertions.sv
`default_nettype none
module spr_port_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic result_valid,
    input wire spr_pkg::spr_result_t result,
    input wire logic result_ready_n,
    input wire logic reg_wr_valid,
    input wire spr_pkg::spr_reg_wr_t reg_wr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Pending flag follows a result write
    a_rdy_new: assert property (result_valid |=> !result_ready_n)
        else $error("ready high after result");
    // Only a selected read can clear pending data
    a_rdy_clear: assert property ($rose(result_ready_n) |-> !$past(ss_n, 6))
        else $error("ready rose outside frame");
    a_oe_on: assert property ($fell(ss_n) |-> ##[2:6] miso_oe)
        else $error("no drive after select");
    a_oe_off: assert property (ss_n [*6] |-> !miso_oe)
        else $error("drive while deselected");
    a_miso_idle: assert property (ss_n [*8] |-> !miso)
        else $error("reply line busy when idle");
    // One store per word, never two in a row
    a_wr_one: assert property (reg_wr_valid |=> !reg_wr_valid)
        else $error("store pulse too long");
    a_wr_page: assert property (reg_wr_valid |-> reg_wr.page inside {4'h1, 4'h2})
        else $error("store to bad page");
    a_wr_sel: assert property (reg_wr_valid |-> !$past(ss_n, 8))
        else $error("store without select");
    cover property (result_valid);
    cover property (reg_wr_valid);
    cover property ($rose(result_ready_n));
endmodule : spr_port_chk
bind spr_port spr_port_chk spr_port_chk_i (
    .clk, .rst_n, .sclk, .ss_n, .mosi, .miso, .miso_oe,
    .result_valid, .result, .result_ready_n, .reg_wr_valid, .reg_wr
);
`default_nettype wire

// >>> verification/spr_master.sv
`default_nettype none
module spr_master (
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Serial clock rests low, select high
    initial
    begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // Odd offset keeps the link out of phase with clk
    task automatic open_frame();
        #7 ss_n = 1'b0;
        #53;
    endtask : open_frame
    // Drive on rise; sample late so slow replies still land
    task automatic word(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b1;
            mosi = tx[i];
            #40 sclk = 1'b0;
            #30 rx[i] = miso;
            #10;
        end
    endtask : word
    // Released data line flips so stale bits never look valid
    task automatic close_frame();
        ss_n = 1'b1;
        mosi = ~mosi;
        #200;
    endtask : close_frame
endmodule : spr_master
`default_nettype wire

// >>> verification/tb_spr_port.sv
`default_nettype none
module tb_spr_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, sclk, ss_n, mosi, miso, miso_oe;
    logic result_valid, result_ready_n, reg_wr_valid;
    spr_pkg::spr_result_t result;
    spr_pkg::spr_reg_wr_t reg_wr;
    spr_pkg::spr_reg_wr_t wrq[$];
    logic [15:0] exp0 [64];
    logic [15:0] coef [3];
    logic [15:0] lfsr, rx;
    logic miso_line;
    int n_mismatch, checks_done;
    spr_port spr_port_i (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .result_valid(result_valid),
        .result(result), .result_ready_n(result_ready_n),
        .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr)
    );
    // Undriven reply line shows the inverse so a stale bit never passes
    assign miso_line = miso_oe ? miso : ~miso;
    spr_master spr_master_i (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_line));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Collect every stored word for later comparison
    always @(negedge clk)
        if (reg_wr_valid === 1'b1)
            wrq.push_back(reg_wr);
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    task automatic check_word(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : check_word
    task automatic check_flag(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask : check_flag
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // Hang guard
    initial
    begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        rst_n = 1'b0;
        result_valid = 1'b0;
        result = '0;
        lfsr = 16'h005A;
        repeat (16) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        check_flag("ready_n", 1'b1, result_ready_n);
        check_flag("miso_oe", 1'b0, miso_oe);
        // Measurement side fills the whole data page
        for (int a = 0; a < 64; a++)
        begin
            lfsr = next_rand(lfsr);
            exp0[a] = lfsr;
            @(negedge clk);
            result_valid = 1'b1;
            result = {a[5:0], lfsr};
        end
        @(negedge clk) result_valid = 1'b0;
        check_flag("ready_n", 1'b0, result_ready_n);
        // Read page from the top and run two words past its end
        spr_master_i.open_frame();
        spr_master_i.word(16'h8000, rx);
        check_word("cmd reply", 16'h0000, rx);
        for (int a = 0; a < 66; a++)
        begin
            lfsr = next_rand(lfsr);
            spr_master_i.word(lfsr, rx);
            check_word("page0 word", (a < 64) ? exp0[a] : 16'hFFFF, rx);
            if (a == 62)
                check_flag("ready_n", 1'b0, result_ready_n);
        end
        spr_master_i.close_frame();
        check_flag("ready_n", 1'b1, result_ready_n);
        // Coefficient burst with junk in the ignored bits
        lfsr = next_rand(lfsr);
        spr_master_i.open_frame();
        spr_master_i.word(16'h10E0 | {11'h000, lfsr[4:0]}, rx);
        for (int k = 0; k < 3; k++)
        begin
            lfsr = next_rand(lfsr);
            coef[k] = lfsr;
            spr_master_i.word(lfsr, rx);
        end
        spr_master_i.close_frame();
        // Read the burst back
        spr_master_i.open_frame();
        spr_master_i.word(16'h90E0, rx);
        for (int k = 0; k < 3; k++)
        begin
            spr_master_i.word(16'h0000, rx);
            check_word("coef read", coef[k], rx);
        end
        spr_master_i.close_frame();
        // Data page write is dropped; reserved page reads all ones
        spr_master_i.open_frame();
        spr_master_i.word(16'h0000, rx);
        spr_master_i.word(16'h1234, rx);
        spr_master_i.close_frame();
        spr_master_i.open_frame();
        spr_master_i.word(16'h98E0, rx);
        spr_master_i.word(16'h0000, rx);
        check_word("reserved page", 16'hFFFF, rx);
        spr_master_i.close_frame();
        // Dropped write must leave the result word untouched
        spr_master_i.open_frame();
        spr_master_i.word(16'h8000, rx);
        spr_master_i.word(16'h0000, rx);
        check_word("page0 kept", exp0[0], rx);
        spr_master_i.close_frame();
        // Single word stored to control register 5, then read back
        lfsr = next_rand(lfsr);
        spr_master_i.open_frame();
        spr_master_i.word(16'h08A0, rx);
        spr_master_i.word(lfsr, rx);
        spr_master_i.close_frame();
        spr_master_i.open_frame();
        spr_master_i.word(16'h88A0, rx);
        spr_master_i.word(16'h0000, rx);
        check_word("ctrl read", lfsr, rx);
        spr_master_i.close_frame();
        check_word("store count", 16'h0004, 16'(wrq.size()));
        for (int k = 0; k < 3; k++)
        begin
            check_word("store page", 16'h0002, {12'h000, wrq[k].page});
            check_word("store addr", 16'(7 + k), {10'h000, wrq[k].addr});
            check_word("store data", coef[k], wrq[k].data);
        end
        check_word("store page", 16'h0001, {12'h000, wrq[3].page});
        check_word("store addr", 16'h0005, {10'h000, wrq[3].addr});
        check_word("store data", lfsr, wrq[3].data);
        report_and_stop();
    end
endmodule : tb_spr_port
`default_nettype wire
